// [hdl/isr_pkg.sv]
package isr_pkg;

  // ****************************************
  // Widths, bit positions, reset values
  // ****************************************
  localparam int REG_W = 16;
  localparam int ZERO_A_BIT = 8;
  localparam int ZERO_B_BIT = 9;
  localparam int SAFETY_BIT = 9;
  localparam int OP_SUM_BIT = 7;
  localparam int ERR_SUM_BIT = 3;
  localparam logic [15:0] OP_USED_MASK = 16'h0300;
  localparam logic [15:0] ERR_USED_MASK = 16'h0200;
  localparam logic [15:0] RISE_RST = 16'hFFFF;
  localparam logic [15:0] FALL_RST = 16'h0000;
  localparam logic [15:0] ENAB_RST = 16'h0000;
  localparam logic [15:0] EVENT_RST = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int DISPLAY_ON_S = 5;
  localparam int DISPLAY_ON_CYC = CLK_HZ * DISPLAY_ON_S;

  // ****************************************
  // Command port
  // ****************************************
  typedef enum logic [1:0] {
    OPC_READ = 2'h0,
    OPC_WRITE = 2'h1,
    OPC_SELFTEST = 2'h2,
    OPC_WAIT = 2'h3
  } isr_opc_e;

  typedef enum logic [2:0] {
    SEL_LIVE = 3'h0,
    SEL_EVENTS = 3'h1,
    SEL_RISE = 3'h2,
    SEL_FALL = 3'h3,
    SEL_MASK = 3'h4
  } isr_sel_e;

  localparam logic NODE_OPERATION = 1'b0;
  localparam logic NODE_ERROR = 1'b1;

  typedef struct packed {
    isr_opc_e opc;
    logic node;
    isr_sel_e sel;
    logic [15:0] data;
  } isr_cmd_s;

  // ****************************************
  // Status node
  // ****************************************
  typedef struct packed {
    logic rise_we;
    logic fall_we;
    logic mask_we;
    logic events_rd;
    logic [15:0] data;
  } isr_node_wr_s;

  typedef struct packed {
    logic [15:0] live;
    logic [15:0] events;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] mask;
    logic summary;
  } isr_node_view_s;

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] events;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] mask;
  } isr_node_s;

  // ****************************************
  // Self-test and sequencer
  // ****************************************
  typedef struct packed {
    logic laser_off;
    logic sweep_stop;
    logic app_menu;
    logic display_all;
  } isr_test_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DISP = 4'b0010,
    ST_PC = 4'b0100,
    ST_HOLD = 4'b1000
  } isr_state_e;

  typedef struct packed {
    isr_state_e st;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0] status_byte;
    isr_test_s test;
    logic pc_start;
    logic [31:0] cnt;
  } isr_top_s;

endpackage

// [hdl/isr_node.sv]
`timescale 1ns/1ns
module isr_node
  import isr_pkg::*;
#(
  parameter logic [15:0] USED_MASK = 16'hFFFF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Live source bits
  input wire logic [15:0] cond,
  // Access and view
  input isr_pkg::isr_node_wr_s wr,
  output isr_pkg::isr_node_view_s view
);
  import isr_pkg::*;

  isr_node_s q;
  isr_node_s d;
  logic [15:0] live;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;

  // ****************************************
  // Edge filters and event latch
  // ****************************************
  assign live = cond & USED_MASK;
  assign rise_hit = live & ~q.prev & q.rise;
  assign fall_hit = ~live & q.prev & q.fall;

  always_comb begin
    d = q;
    d.prev = live;
    // New events win over the clearing read
    d.events = ((wr.events_rd ? EVENT_RST : q.events) | rise_hit | fall_hit) & USED_MASK;
    if (wr.rise_we) begin
      d.rise = wr.data & USED_MASK;
    end
    if (wr.fall_we) begin
      d.fall = wr.data & USED_MASK;
    end
    if (wr.mask_we) begin
      d.mask = wr.data & USED_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q.prev <= 16'h0000;
      q.events <= EVENT_RST;
      q.rise <= RISE_RST & USED_MASK;
      q.fall <= FALL_RST;
      q.mask <= ENAB_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  always_comb begin
    view.live = live;
    view.events = q.events;
    view.rise = q.rise;
    view.fall = q.fall;
    view.mask = q.mask;
    view.summary = |(q.events & q.mask);
  end

  // ****************************************
  // Checks
  // ****************************************
  a_rise_sets_event: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rise_hit != 16'h0000) |=> ((q.events & $past(rise_hit)) == $past(rise_hit)))
    else $error("rising edge did not latch event");

  a_fall_sets_event: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && fall_hit != 16'h0000) |=> ((q.events & $past(fall_hit)) == $past(fall_hit)))
    else $error("falling edge did not latch event");

  a_read_clears_events: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && wr.events_rd && rise_hit == 16'h0000 && fall_hit == 16'h0000)
    |=> q.events == 16'h0000)
    else $error("event register not cleared by read");

  a_filter_reset: assert property (@(posedge ref_clk)
    rst |=> (q.rise == (RISE_RST & USED_MASK) && q.fall == FALL_RST))
    else $error("filters wrong after reset");

  a_event_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !wr.events_rd) |=> ((q.events & $past(q.events)) == $past(q.events)))
    else $error("event bit dropped without read");

endmodule

// [hdl/isr_top.sv]
`timescale 1ns/1ns
// How it works
// - Two status nodes: operation for normal activity, error for fault conditions.
// - Each node has live, events, rising filter, falling filter, mask; 16 bits.
// - Live register always shows the current synchronised source bits.
// - Reading the events register returns it and then clears it.
// - Live bit rising with its rising filter bit set latches the event bit.
// - Rising filter comes up with all used bits set after reset.
// - Live bit falling with its falling filter bit set latches the event bit.
// - Falling filter comes up all zeros after reset.
// - Masked operation events drive status byte bit 7.
// - Masked error events drive status byte bit 3.
// - All five registers readable; filters and mask writable.
// - Operation bits 8 and 9 show channel A and B zeroing.
// - Error bit 9 is safety: power monitor switched the laser off.
// - Self-test: laser off, sweep stop, menu, then polarization check.
// - Self-test lights every display pixel for about five seconds.
// - Self-test answer is 0 on pass, 1 on fail.
// - After self-test the settings in force before it come back.
// - Wait command holds off further commands until pending work ends.
module isr_top
  import isr_pkg::*;
#(
  parameter int DISP_CYCLES = DISPLAY_ON_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Command from the remote controller
  input wire logic cmd_valid,
  output logic cmd_ready,
  input isr_pkg::isr_cmd_s cmd,
  // Answer to queries
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // Status byte summary bits
  output logic [7:0] status_byte,
  // Status sources from pins
  input wire logic zeroing_a,
  input wire logic zeroing_b,
  input wire logic laser_tripped,
  // Pending instrument work
  input wire logic ops_pending,
  // Polarization controller check
  output logic pc_check_start,
  input wire logic pc_check_done,
  input wire logic pc_check_fail,
  // Self-test overrides of instrument settings
  output isr_pkg::isr_test_s test_ctl,
  output logic selftest_busy
);
  import isr_pkg::*;

  isr_top_s q;
  isr_top_s d;
  logic accept;
  logic [15:0] op_cond;
  logic [15:0] err_cond;
  isr_node_wr_s op_wr;
  isr_node_wr_s err_wr;
  isr_node_view_s op_view;
  isr_node_view_s err_view;

  // ****************************************
  // Register read selector
  // ****************************************
  function automatic logic [15:0] read_reg(input isr_node_view_s v, input isr_sel_e sel);
    logic [15:0] r;
    r = 16'h0000;
    unique case (sel)
      SEL_LIVE: r = v.live;
      SEL_EVENTS: r = v.events;
      SEL_RISE: r = v.rise;
      SEL_FALL: r = v.fall;
      SEL_MASK: r = v.mask;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  function automatic isr_node_wr_s node_access(input logic hit, input isr_cmd_s c);
    isr_node_wr_s w;
    w = '0;
    w.data = c.data;
    w.events_rd = hit && c.opc == OPC_READ && c.sel == SEL_EVENTS;
    w.rise_we = hit && c.opc == OPC_WRITE && c.sel == SEL_RISE;
    w.fall_we = hit && c.opc == OPC_WRITE && c.sel == SEL_FALL;
    w.mask_we = hit && c.opc == OPC_WRITE && c.sel == SEL_MASK;
    return w;
  endfunction

  // ****************************************
  // Status sources
  // ****************************************
  always_comb begin
    op_cond = 16'h0000;
    op_cond[ZERO_A_BIT] = q.sync2[0];
    op_cond[ZERO_B_BIT] = q.sync2[1];
    err_cond = 16'h0000;
    err_cond[SAFETY_BIT] = q.sync2[2];
  end

  // Only idle commands reach the nodes
  assign cmd_ready = ce && (q.st == ST_IDLE);
  assign accept = cmd_valid && cmd_ready;
  assign op_wr = node_access(accept && cmd.node == NODE_OPERATION, cmd);
  assign err_wr = node_access(accept && cmd.node == NODE_ERROR, cmd);

  // ****************************************
  // Status nodes
  // ****************************************
  isr_node #(
    .USED_MASK(OP_USED_MASK)
  ) u_operation_node (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .cond(op_cond),
    .wr(op_wr),
    .view(op_view)
  );

  isr_node #(
    .USED_MASK(ERR_USED_MASK)
  ) u_error_node (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .cond(err_cond),
    .wr(err_wr),
    .view(err_view)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.pc_start = 1'b0;
    d.sync1 = {laser_tripped, zeroing_b, zeroing_a};
    d.sync2 = q.sync1;
    d.status_byte = 8'h00;
    d.status_byte[OP_SUM_BIT] = op_view.summary;
    d.status_byte[ERR_SUM_BIT] = err_view.summary;
    unique case (q.st)
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd.opc)
            OPC_READ: begin
              d.rsp_valid = 1'b1;
              d.rsp_data = read_reg(cmd.node ? err_view : op_view, cmd.sel);
            end
            OPC_WRITE: begin
              d.rsp_data = q.rsp_data;
            end
            OPC_SELFTEST: begin
              d.test = '{laser_off: 1'b1, sweep_stop: 1'b1,
                         app_menu: 1'b1, display_all: 1'b1};
              d.cnt = 32'(DISP_CYCLES - 1);
              d.st = ST_DISP;
            end
            OPC_WAIT: begin
              d.st = ST_HOLD;
            end
          endcase
        end
      end
      ST_DISP: begin
        if (q.cnt == 32'h0000_0000) begin
          d.test.display_all = 1'b0;
          d.pc_start = 1'b1;
          d.st = ST_PC;
        end else begin
          d.cnt = q.cnt - 32'h0000_0001;
        end
      end
      ST_PC: begin
        if (pc_check_done) begin
          d.test = '0;
          d.rsp_valid = 1'b1;
          d.rsp_data = {15'h0000, pc_check_fail};
          d.st = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!ops_pending) begin
          d.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign status_byte = q.status_byte;
  assign pc_check_start = q.pc_start;
  assign test_ctl = q.test;
  assign selftest_busy = (q.st == ST_DISP) || (q.st == ST_PC);

  // ****************************************
  // Checks
  // ****************************************
  sequence s_test_taken;
    accept && cmd.opc == OPC_SELFTEST;
  endsequence

  sequence s_overrides_on;
    test_ctl.laser_off && test_ctl.sweep_stop && test_ctl.app_menu && test_ctl.display_all;
  endsequence

  property p_test_entry;
    @(posedge ref_clk) disable iff (rst)
    s_test_taken |=> s_overrides_on ##0 (selftest_busy && !pc_check_start);
  endproperty

  a_test_entry: assert property (p_test_entry)
    else $error("self-test did not apply overrides");

  a_display_count: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && q.st == ST_DISP && q.cnt == 32'h0000_0000)
    |=> (pc_check_start && !test_ctl.display_all && q.st == ST_PC))
    else $error("display phase did not hand over to check");

  a_test_result: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && q.st == ST_PC && pc_check_done)
    |=> (rsp_valid && rsp_data == {15'h0000, $past(pc_check_fail)} && test_ctl == '0))
    else $error("self-test result or restore wrong");

  a_busy_refuses: assert property (@(posedge ref_clk) disable iff (rst)
    (selftest_busy || (q.st == ST_HOLD)) |-> !cmd_ready)
    else $error("command accepted while busy");

  a_wait_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && accept && cmd.opc == OPC_WAIT) ##1 ops_pending[*2] |-> !cmd_ready)
    else $error("wait released with work pending");

  a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && cmd.opc == OPC_READ && cmd.node == NODE_OPERATION && cmd.sel == SEL_MASK)
    |=> (rsp_valid && rsp_data == $past(op_view.mask)))
    else $error("read answer wrong");

  logic op_sum_ref;
  logic err_sum_ref;
  assign op_sum_ref = |(op_view.events & op_view.mask);
  assign err_sum_ref = |(err_view.events & err_view.mask);

  a_summary_bits: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> (status_byte[OP_SUM_BIT] == $past(op_sum_ref)
            && status_byte[ERR_SUM_BIT] == $past(err_sum_ref)))
    else $error("status byte summary wrong");

  a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (rsp_valid && !$past(selftest_busy)) |-> ((rsp_data & ~(OP_USED_MASK | ERR_USED_MASK)) == 16'h0000))
    else $error("unused bits read nonzero");

  a_status_unused: assert property (@(posedge ref_clk) disable iff (rst)
    (status_byte & ~((8'h01 << OP_SUM_BIT) | (8'h01 << ERR_SUM_BIT))) == 8'h00)
    else $error("status byte spare bit set");

  a_wait_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && cmd.opc == OPC_WAIT) |=> (q.st == ST_HOLD && !selftest_busy))
    else $error("wait command did not hold");

  a_wait_release: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && q.st == ST_HOLD && !ops_pending) ##1 ce |-> cmd_ready)
    else $error("wait did not release when work ended");

  a_busy_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (selftest_busy || (q.st == ST_HOLD)) |-> !rsp_valid)
    else $error("answer given while busy");

  a_start_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pc_check_start) |=> !pc_check_start)
    else $error("check start longer than one cycle");

  a_overrides_held: assert property (@(posedge ref_clk) disable iff (rst)
    selftest_busy |-> (test_ctl.laser_off && test_ctl.sweep_stop && test_ctl.app_menu))
    else $error("override dropped during self-test");

  a_restore_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !selftest_busy |-> test_ctl == '0)
    else $error("settings not restored outside self-test");

  a_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && cmd.opc == OPC_WRITE && cmd.node == NODE_OPERATION && cmd.sel == SEL_MASK)
    |=> op_view.mask == ($past(cmd.data) & OP_USED_MASK))
    else $error("mask write did not land");

  a_live_synced: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2))
    |-> (op_view.live[ZERO_A_BIT] == $past(zeroing_a, 2)
         && err_view.live[SAFETY_BIT] == $past(laser_tripped, 2)))
    else $error("live bit not two cycles behind its pin");

endmodule

// [tb/isr_instr_model.sv]
`timescale 1ns/1ns
module isr_instr_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Polarization check handshake
  input wire logic pc_check_start,
  output logic pc_check_done,
  output logic pc_check_fail,
  // Behaviour chosen by the bench
  input wire logic fail_mode,
  input wire logic [7:0] delay
);
  logic [7:0] cnt_q;
  logic busy_q;

  // ****************************************
  // Check answered after a delay
  // ****************************************
  always_ff @(posedge ref_clk) begin
    pc_check_done <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      pc_check_fail <= 1'b0;
    end else if (pc_check_start) begin
      busy_q <= 1'b1;
      cnt_q <= delay;
      pc_check_fail <= ~pc_check_fail;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'b0;
      pc_check_done <= 1'b1;
      pc_check_fail <= fail_mode;
    end else begin
      // Fail line is meaningless outside the done cycle
      cnt_q <= cnt_q - 8'h01;
      pc_check_fail <= ~pc_check_fail;
    end
  end
endmodule

// [tb/instrument_status_reporting_tb_top.sv]
`timescale 1ns/1ns
module instrument_status_reporting_tb_top;
  import isr_pkg::*;
  localparam int DISP = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  isr_cmd_s cmd = '0;
  logic zeroing_a = 1'b0;
  logic zeroing_b = 1'b0;
  logic laser_tripped = 1'b0;
  logic ops_pending = 1'b0;
  logic fail_mode = 1'b0;
  logic [7:0] delay = 8'h03;
  logic cmd_ready, rsp_valid, pc_check_start, pc_check_done, pc_check_fail, selftest_busy;
  logic [15:0] rsp_data;
  logic [7:0] status_byte;
  isr_test_s test_ctl;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h8A3F;
  logic [31:0] r;

  isr_top #(.DISP_CYCLES(DISP)) i_isr_top (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .status_byte(status_byte), .zeroing_a(zeroing_a),
    .zeroing_b(zeroing_b), .laser_tripped(laser_tripped), .ops_pending(ops_pending),
    .pc_check_start(pc_check_start), .pc_check_done(pc_check_done),
    .pc_check_fail(pc_check_fail), .test_ctl(test_ctl), .selftest_busy(selftest_busy));

  isr_instr_model i_isr_instr_model (.ref_clk(ref_clk), .rst(rst),
    .pc_check_start(pc_check_start), .pc_check_done(pc_check_done),
    .pc_check_fail(pc_check_fail), .fail_mode(fail_mode), .delay(delay));

  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected timeout expected 20000 seen %0d", cycles);
      print_verdict();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    logic [31:0] s;
    s = seed;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    seed = s;
    return s;
  endfunction

  // Only the used bits of a node keep a written value
  function automatic logic [15:0] exp_used(input logic nd, input logic [15:0] v);
    return v & (nd ? ERR_USED_MASK : OP_USED_MASK);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold keeps valid up for a back-to-back command
  task automatic go(input isr_opc_e o, input logic nd, input isr_sel_e s,
                    input logic [15:0] d, input logic hold);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    cmd_valid = 1'b1;
    cmd = '{o, nd, s, d};
    step(1);
    if (!hold) cmd_valid = 1'b0;
  endtask

  task automatic rdc(input string what, input logic nd, input isr_sel_e s,
                     input logic [15:0] exp, input logic hold);
    go(OPC_READ, nd, s, 16'h0000, hold);
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk(what, exp, rsp_data);
  endtask

  task automatic selftest(input logic fl);
    int n;
    int hi;
    n = 0;
    hi = 0;
    fail_mode = fl;
    go(OPC_SELFTEST, NODE_OPERATION, SEL_LIVE, 16'h0000, 1'b0);
    chk("overrides on", 16'h000F, {12'h000, test_ctl});
    chk("busy", 16'h0001, {15'h0000, selftest_busy});
    while (rsp_valid !== 1'b1 && n < 300) begin
      if (test_ctl.display_all === 1'b1) hi++;
      step(1);
      n++;
    end
    chk("display time", 16'h0001, {15'h0000, hi >= DISP && hi <= DISP + 1});
    chk("overrides off", 16'h0000, {12'h000, test_ctl});
    chk("self-test result", {15'h0000, fl}, rsp_data);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    step(4);
    rst = 1'b0;
    rdc("op rise", NODE_OPERATION, SEL_RISE, 16'h0300, 1'b0);
    rdc("err rise", NODE_ERROR, SEL_RISE, 16'h0200, 1'b1);
    rdc("op fall", NODE_OPERATION, SEL_FALL, 16'h0000, 1'b1);
    rdc("err fall", NODE_ERROR, SEL_FALL, 16'h0000, 1'b0);
    $display("test reset_values done");
    zeroing_a = 1'b1;
    step(6);
    rdc("op live", NODE_OPERATION, SEL_LIVE, 16'h0100, 1'b0);
    step(3);
    rdc("op events", NODE_OPERATION, SEL_EVENTS, 16'h0100, 1'b1);
    rdc("events cleared", NODE_OPERATION, SEL_EVENTS, 16'h0000, 1'b0);
    go(OPC_WRITE, NODE_OPERATION, SEL_LIVE, 16'hFFFF, 1'b0);
    rdc("live unwritable", NODE_OPERATION, SEL_LIVE, 16'h0100, 1'b0);
    rdc("unknown sel", NODE_OPERATION, isr_sel_e'(3'h7), 16'h0000, 1'b0);
    $display("test rising_edges done");
    go(OPC_WRITE, NODE_OPERATION, SEL_FALL, 16'hFFFF, 1'b1);
    go(OPC_WRITE, NODE_OPERATION, SEL_RISE, 16'h0000, 1'b0);
    rdc("op fall written", NODE_OPERATION, SEL_FALL, 16'h0300, 1'b0);
    zeroing_b = 1'b1;
    step(6);
    rdc("rise filtered", NODE_OPERATION, SEL_EVENTS, 16'h0000, 1'b0);
    zeroing_a = 1'b0;
    zeroing_b = 1'b0;
    step(6);
    rdc("fall events", NODE_OPERATION, SEL_EVENTS, 16'h0300, 1'b0);
    $display("test falling_edges done");
    go(OPC_WRITE, NODE_OPERATION, SEL_MASK, 16'h0200, 1'b0);
    rdc("op mask", NODE_OPERATION, SEL_MASK, 16'h0200, 1'b0);
    zeroing_b = 1'b1;
    step(6);
    zeroing_b = 1'b0;
    step(6);
    chk("status byte", 16'h0080, {8'h00, status_byte});
    rdc("op events", NODE_OPERATION, SEL_EVENTS, 16'h0200, 1'b0);
    step(3);
    chk("status byte", 16'h0000, {8'h00, status_byte});
    zeroing_a = 1'b1;
    step(6);
    zeroing_a = 1'b0;
    step(6);
    chk("status byte", 16'h0000, {8'h00, status_byte});
    rdc("op events", NODE_OPERATION, SEL_EVENTS, 16'h0100, 1'b0);
    go(OPC_WRITE, NODE_ERROR, SEL_MASK, 16'hFFFF, 1'b0);
    laser_tripped = 1'b1;
    step(6);
    chk("status byte", 16'h0008, {8'h00, status_byte});
    rdc("err live", NODE_ERROR, SEL_LIVE, 16'h0200, 1'b1);
    rdc("err events", NODE_ERROR, SEL_EVENTS, 16'h0200, 1'b0);
    laser_tripped = 1'b0;
    $display("test summary_bits done");
    for (int k = 0; k < 8; k++) begin
      r = xs();
      go(OPC_WRITE, r[0], r[1] ? SEL_FALL : SEL_MASK, r[31:16], 1'b0);
      rdc("random rw", r[0], r[1] ? SEL_FALL : SEL_MASK,
          exp_used(r[0], r[31:16]), 1'b0);
    end
    $display("test random_access done");
    ops_pending = 1'b1;
    go(OPC_WAIT, NODE_OPERATION, SEL_LIVE, 16'h0000, 1'b0);
    step(3);
    chk("ready in wait", 16'h0000, {15'h0000, cmd_ready});
    ops_pending = 1'b0;
    step(2);
    chk("ready after wait", 16'h0001, {15'h0000, cmd_ready});
    $display("test wait done");
    // Nothing else is sent while the self-test runs
    selftest(1'b0);
    selftest(1'b1);
    $display("test self_test done");
    print_verdict();
  end
endmodule
